// ===== common/wdl_cfg.svh
`ifndef WDL_CFG_SVH
`define WDL_CFG_SVH

`define WDL_CTRL_ADDR        16'h0000
`define WDL_KEY_ADDR         16'h0004
`define WDL_STAGE_ADDR       16'h0008
`define WDL_STATUS_ADDR      16'h000C
`define WDL_LOCK_IDX         16'h3FFA
`define WDL_PROT_FIRST_IDX   16'h3FFB
`define WDL_PROT_LAST_IDX    16'h3FFF
`define WDL_PROT_SLOTS       5
`define WDL_CTRL_RST         8'h72
`define WDL_LOCK_BYTE_RST    8'hFF
`define WDL_PROT_RST         8'hFF
`define WDL_LOCK_BIT         7
`define WDL_SEL_LAST_PERIOD  4'h7
`define WDL_SEL_RESET_NOW    4'h8
`define WDL_SEL_DOWNLOAD_NOW 4'h9
`define WDL_RESP_OKAY        2'h0
`define WDL_RESP_SLVERR      2'h2
`define WDL_CLK_PERIOD_NS    4
`define WDL_BASE_TIMEOUT_US  15600
`define WDL_TICK_CYCLES      ((`WDL_BASE_TIMEOUT_US * 1000) / `WDL_CLK_PERIOD_NS)

`endif

// ===== common/wdl_pkg.sv
`include "wdl_cfg.svh"
package wdl_pkg;

  typedef struct packed {
    logic [3:0] sel;
    logic       resp_irq;
    logic       flag;
    logic       en;
    logic       unlock;
  } wdl_ctrl_type;

  typedef enum logic [2:0] {
    WDL_REG_CTRL,
    WDL_REG_KEY,
    WDL_REG_STAGE,
    WDL_REG_STATUS,
    WDL_REG_LOCK,
    WDL_REG_PROT,
    WDL_REG_NONE
  } wdl_reg_type;

  typedef enum logic [1:0] {
    WDL_SEL_PERIOD,
    WDL_SEL_RESET,
    WDL_SEL_DOWNLOAD,
    WDL_SEL_INVALID
  } wdl_sel_kind_type;

  function automatic wdl_reg_type wdl_decode(input logic [15:0] addr);
    logic [15:0] idx;
    idx = {2'h0, addr[15:2]};
    if (addr[1:0] != 2'h0) return WDL_REG_NONE;
    if (addr == `WDL_CTRL_ADDR) return WDL_REG_CTRL;
    if (addr == `WDL_KEY_ADDR) return WDL_REG_KEY;
    if (addr == `WDL_STAGE_ADDR) return WDL_REG_STAGE;
    if (addr == `WDL_STATUS_ADDR) return WDL_REG_STATUS;
    if (idx == `WDL_LOCK_IDX) return WDL_REG_LOCK;
    if (idx >= `WDL_PROT_FIRST_IDX && idx <= `WDL_PROT_LAST_IDX) begin
      return WDL_REG_PROT;
    end
    return WDL_REG_NONE;
  endfunction : wdl_decode

  function automatic logic [2:0] wdl_slot(input logic [15:0] addr);
    logic [15:0] diff;
    diff = {2'h0, addr[15:2]} - `WDL_PROT_FIRST_IDX;
    return diff[2:0];
  endfunction : wdl_slot

  function automatic wdl_sel_kind_type wdl_sel_kind(input logic [3:0] sel);
    if (sel <= `WDL_SEL_LAST_PERIOD) return WDL_SEL_PERIOD;
    if (sel == `WDL_SEL_RESET_NOW) return WDL_SEL_RESET;
    if (sel == `WDL_SEL_DOWNLOAD_NOW) return WDL_SEL_DOWNLOAD;
    return WDL_SEL_INVALID;
  endfunction : wdl_sel_kind

endpackage : wdl_pkg

// ===== common/wdl_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface wdl_reg_if;
  logic        wr_en;
  logic [15:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_en;
  logic [15:0] rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  modport slave_side (
    output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    input  wr_err, rd_data, rd_err
  );
  modport regs_side (
    input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
    output wr_err, rd_data, rd_err
  );
endinterface : wdl_reg_if
`default_nettype wire

// ===== logic/wdl_axil_slave.sv
`include "wdl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module wdl_axil_slave
  import wdl_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [15:0]  awaddr,
  input  wire logic         awvalid,
  output var  logic         awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output var  logic         wready,
  output var  logic [1:0]   bresp,
  output var  logic         bvalid,
  input  wire logic         bready,
  input  wire logic [15:0]  araddr,
  input  wire logic         arvalid,
  output var  logic         arready,
  output var  logic [31:0]  rdata,
  output var  logic [1:0]   rresp,
  output var  logic         rvalid,
  input  wire logic         rready,
  wdl_reg_if.slave_side     regs
);
  logic        aw_full_q, aw_full_d, w_full_q, w_full_d, ar_full_q, ar_full_d;
  logic [15:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_d;
  logic [3:0]  wstrb_q, wstrb_d;
  logic        bvalid_d, rvalid_d;
  logic [1:0]  bresp_d, rresp_d;

  // Address and data are held until both are present, then one strobe.
  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    ar_full_d = ar_full_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    araddr_d  = araddr_q;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    rvalid_d  = rvalid;
    rresp_d   = rresp;
    rdata_d   = rdata;
    awready   = !aw_full_q && !bvalid;
    wready    = !w_full_q && !bvalid;
    arready   = !ar_full_q && !rvalid;
    regs.wr_en   = aw_full_q && w_full_q;
    regs.wr_addr = awaddr_q;
    regs.wr_data = wdata_q;
    regs.wr_strb = wstrb_q;
    regs.rd_en   = ar_full_q;
    regs.rd_addr = araddr_q;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      awaddr_d  = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (bvalid && bready) bvalid_d = 1'b0;
    if (regs.wr_en) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = regs.wr_err ? `WDL_RESP_SLVERR : `WDL_RESP_OKAY;
    end
    if (arvalid && arready) begin
      ar_full_d = 1'b1;
      araddr_d  = araddr;
    end
    if (rvalid && rready) rvalid_d = 1'b0;
    if (regs.rd_en) begin
      ar_full_d = 1'b0;
      rvalid_d  = 1'b1;
      rdata_d   = regs.rd_data;
      rresp_d   = regs.rd_err ? `WDL_RESP_SLVERR : `WDL_RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      ar_full_q <= 1'b0;
      awaddr_q  <= 16'h0000;
      araddr_q  <= 16'h0000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `WDL_RESP_OKAY;
      rvalid    <= 1'b0;
      rresp     <= `WDL_RESP_OKAY;
      rdata     <= 32'h0000_0000;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      ar_full_q <= ar_full_d;
      awaddr_q  <= awaddr_d;
      araddr_q  <= araddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid    <= bvalid_d;
      bresp     <= bresp_d;
      rvalid    <= rvalid_d;
      rresp     <= rresp_d;
      rdata     <= rdata_d;
    end
  end
endmodule : wdl_axil_slave
`default_nettype wire

// ===== logic/wdl_timebase.sv
`timescale 1ns/10ps
`default_nettype none
module wdl_timebase #(
  parameter int unsigned TICK_CYCLES = 16
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic run,
  input  wire logic clear,
  output var  logic tick
);
  localparam logic [21:0] LAST = 22'(TICK_CYCLES - 1);
  logic [21:0] cnt_q, cnt_d;
  logic        tick_d;

  // Emits one pulse per base period while running.
  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (clear || !run) begin
      cnt_d = 22'h00_0000;
    end else if (cnt_q == LAST) begin
      cnt_d  = 22'h00_0000;
      tick_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 22'h00_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 22'h00_0000;
      tick  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule : wdl_timebase
`default_nettype wire

// ===== logic/wdl_top.sv
// Function
// - A zero lock bit holds enable on and response at reset.
// - The timeout field in bits 7 to 4 stays writable even while locked.
// - The lock bit is key bit 7, so a locked part keys 0x7F, not 0xFF.
// - A key write that matches the stored key byte stores the staged value.
// - The lock and key byte lives at index 0x3FFA and its bits erase to one.
// - A control write counts only right after the write-unlock was set.
// - An expired timeout resets the system unless interrupt response is set.
// - Bit 3 of the control register selects interrupt instead of reset.
// - The timeout interrupt is high priority and no global enable masks it.
// - In interrupt response the watchdog keeps running and fires again.
// - Codes 0-7 give 15.6 ms to 2 s; 8 resets, 9 download-resets, 10-15 void.
// - Setting the enable bit enables the watchdog and clears its counter.
// - Timeout sets the flag, and only zero writes or pin resets clear it.
`include "wdl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module wdl_top
  import wdl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `WDL_TICK_CYCLES
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         por_n,
  input  wire logic [15:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output var  logic         s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output var  logic         s_axi_wready,
  output var  logic [1:0]   s_axi_bresp,
  output var  logic         s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [15:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output var  logic         s_axi_arready,
  output var  logic [31:0]  s_axi_rdata,
  output var  logic [1:0]   s_axi_rresp,
  output var  logic         s_axi_rvalid,
  input  wire logic         s_axi_rready,
  output var  logic         wdt_sys_reset,
  output var  logic         wdt_download_reset,
  output var  logic         wdt_irq
);
  wdl_reg_if regs_if ();

  wdl_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .regs    (regs_if.slave_side)
  );

  wdl_ctrl_type ctrl_q, ctrl_d;
  logic         locked_q, locked_d;
  logic [7:0]   key_q, key_d;
  logic [10:0]  stage_q, stage_d;
  logic         match_q, match_d;
  logic [7:0]   tick_cnt_q, tick_cnt_d;
  logic         sys_rst_d, dl_rst_d, irq_d;
  logic [7:0]   lock_byte_q, lock_byte_d;
  logic [7:0]   prot_q [`WDL_PROT_SLOTS];
  logic [7:0]   prot_d [`WDL_PROT_SLOTS];

  wdl_reg_type  wsel, rsel;
  logic [7:0]   wbyte;
  logic         lane0, access, ctrl_wr, ctrl_ok, key_wr, key_hit;
  logic         tick, tb_clear, timeout, self_rst;
  logic [7:0]   tick_last;

  // Both immediate-reset codes and a timeout reset re-initialise the control
  // register (bar the flag), lock state and timeout count one cycle later, the way the rest of the chip would see it.
  assign self_rst = wdt_sys_reset || wdt_download_reset;

  assign wsel    = wdl_decode(regs_if.wr_addr);
  assign rsel    = wdl_decode(regs_if.rd_addr);
  assign wbyte   = regs_if.wr_data[7:0];
  assign lane0   = regs_if.wr_strb[0];
  assign access  = regs_if.wr_en || regs_if.rd_en;
  assign ctrl_wr = regs_if.wr_en && wsel == WDL_REG_CTRL && lane0;
  assign ctrl_ok = ctrl_wr && ctrl_q.unlock;
  assign key_wr  = regs_if.wr_en && wsel == WDL_REG_KEY && lane0;
  assign key_hit = key_wr && wbyte == lock_byte_q;
  assign regs_if.wr_err = regs_if.wr_en && wsel == WDL_REG_NONE;

  assign tick_last = (8'h01 << ctrl_q.sel[2:0]) - 8'h01;
  assign timeout   = ctrl_q.en && tick && tick_cnt_q == tick_last;
  assign tb_clear  = self_rst || (ctrl_ok && wbyte[1]);

  wdl_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (ctrl_q.en),
    .clear   (tb_clear),
    .tick    (tick)
  );

  always_comb begin
    ctrl_d     = ctrl_q;
    locked_d   = locked_q;
    key_d      = key_q;
    stage_d    = stage_q;
    match_d    = match_q;
    tick_cnt_d = tick_cnt_q;
    sys_rst_d  = 1'b0;
    dl_rst_d   = 1'b0;
    irq_d      = 1'b0;

    if (ctrl_q.en && tick) begin
      tick_cnt_d = timeout ? 8'h00 : tick_cnt_q + 8'h01;
    end
    if (timeout) begin
      if (ctrl_q.resp_irq) begin
        irq_d = 1'b1;
      end else begin
        sys_rst_d = 1'b1;
      end
    end

    if (ctrl_wr && !ctrl_q.unlock && wbyte[0]) begin
      ctrl_d.unlock = 1'b1;
    end else if (access) begin
      ctrl_d.unlock = 1'b0;
    end

    if (ctrl_ok) begin
      unique case (wdl_sel_kind(wbyte[7:4]))
        WDL_SEL_PERIOD:   ctrl_d.sel = wbyte[7:4];
        WDL_SEL_RESET:    sys_rst_d  = 1'b1;
        WDL_SEL_DOWNLOAD: dl_rst_d   = 1'b1;
        WDL_SEL_INVALID:  ctrl_d.sel = ctrl_q.sel;
      endcase
      ctrl_d.resp_irq = wbyte[3];
      ctrl_d.en       = wbyte[1];
      if (!wbyte[2]) ctrl_d.flag = 1'b0;
      if (wbyte[1] || wdl_sel_kind(wbyte[7:4]) == WDL_SEL_PERIOD) begin
        tick_cnt_d = 8'h00;
      end
    end
    if (timeout) ctrl_d.flag = 1'b1;

    if (locked_q) begin
      ctrl_d.en       = 1'b1;
      ctrl_d.resp_irq = 1'b0;
    end

    if (key_wr) begin
      key_d   = wbyte;
      match_d = key_hit;
    end
    if (regs_if.wr_en && wsel == WDL_REG_STAGE) begin
      if (lane0) stage_d[7:0] = wbyte;
      if (regs_if.wr_strb[1]) stage_d[10:8] = regs_if.wr_data[10:8];
    end

    if (self_rst) begin
      ctrl_d      = wdl_ctrl_type'(`WDL_CTRL_RST);
      ctrl_d.flag = ctrl_q.flag;
      locked_d    = !lock_byte_q[`WDL_LOCK_BIT];
      tick_cnt_d  = 8'h00;
      sys_rst_d   = 1'b0;
      dl_rst_d    = 1'b0;
      irq_d       = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q             <= wdl_ctrl_type'(`WDL_CTRL_RST);
      locked_q           <= !lock_byte_q[`WDL_LOCK_BIT];
      key_q              <= 8'h00;
      stage_q            <= 11'h7FF;
      match_q            <= 1'b0;
      tick_cnt_q         <= 8'h00;
      wdt_sys_reset      <= 1'b0;
      wdt_download_reset <= 1'b0;
      wdt_irq            <= 1'b0;
    end else begin
      ctrl_q             <= ctrl_d;
      locked_q           <= locked_d;
      key_q              <= key_d;
      stage_q            <= stage_d;
      match_q            <= match_d;
      tick_cnt_q         <= tick_cnt_d;
      wdt_sys_reset      <= sys_rst_d;
      wdt_download_reset <= dl_rst_d;
      wdt_irq            <= irq_d;
    end
  end

  // Flash-resident bytes survive pin and watchdog resets; lock byte writes can
  // only clear bits, a key hit overwrites a whole protect slot, and only a
  // power-on reset erases them back to ones.
  always_comb begin
    lock_byte_d = lock_byte_q;
    for (int i = 0; i < `WDL_PROT_SLOTS; i++) begin
      prot_d[i] = prot_q[i];
    end
    if (regs_if.wr_en && wsel == WDL_REG_LOCK && lane0) begin
      lock_byte_d = lock_byte_q & wbyte;
    end
    if (key_hit && stage_q[10:8] < 3'(`WDL_PROT_SLOTS)) begin
      prot_d[stage_q[10:8]] = stage_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      lock_byte_q <= `WDL_LOCK_BYTE_RST;
      for (int i = 0; i < `WDL_PROT_SLOTS; i++) begin
        prot_q[i] <= `WDL_PROT_RST;
      end
    end else begin
      lock_byte_q <= lock_byte_d;
      for (int i = 0; i < `WDL_PROT_SLOTS; i++) begin
        prot_q[i] <= prot_d[i];
      end
    end
  end

  always_comb begin
    regs_if.rd_data = 32'h0000_0000;
    regs_if.rd_err  = 1'b0;
    unique case (rsel)
      WDL_REG_CTRL:   regs_if.rd_data[7:0]  = ctrl_q;
      WDL_REG_KEY:    regs_if.rd_data[7:0]  = key_q;
      WDL_REG_STAGE:  regs_if.rd_data[10:0] = stage_q;
      WDL_REG_STATUS: regs_if.rd_data[1:0]  = {match_q, locked_q};
      WDL_REG_LOCK:   regs_if.rd_data[7:0]  = lock_byte_q;
      WDL_REG_PROT:   regs_if.rd_data[7:0] = prot_q[wdl_slot(regs_if.rd_addr)];
      WDL_REG_NONE:   regs_if.rd_err        = 1'b1;
      default:        regs_if.rd_err        = 1'b1;
    endcase
  end
endmodule : wdl_top
`default_nettype wire

// ===== verification/wdl_top_props.sv
`include "wdl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module wdl_top_props #(
  parameter int unsigned TICK_CYCLES = 16
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        wdt_sys_reset,
  input wire logic        wdt_download_reset,
  input wire logic        wdt_irq
);
  logic [31:0] gap_q;
  logic [31:0] gap_d;

  // Cycles since the last watchdog pulse of any kind.
  always_comb begin
    gap_d = gap_q + 32'h0000_0001;
    if (wdt_irq || wdt_sys_reset || wdt_download_reset) begin
      gap_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 32'h0000_0000;
    end else begin
      gap_q <= gap_d;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (
    s_wr_taken |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_read_answer: assert property (
    s_rd_taken |-> ##[1:3] s_axi_rvalid) else $error("read answer late");
  a_write_blocked: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_read_blocked: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while pending");
  a_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == `WDL_RESP_SLVERR |-> s_axi_rdata == '0)
    else $error("error read returned data");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:11] == '0) else $error("upper bits set");
  a_irq_pulse: assert property (
    wdt_irq |=> !wdt_irq) else $error("interrupt longer than one cycle");
  a_reset_pulse: assert property (
    wdt_sys_reset |=> !wdt_sys_reset && !wdt_irq)
    else $error("reset pulse malformed");
  a_irq_gap: assert property (
    wdt_irq |-> gap_q >= TICK_CYCLES - 2) else $error("timeout too short");
  a_one_cause: assert property (
    !(wdt_irq && (wdt_sys_reset || wdt_download_reset)) &&
    !(wdt_sys_reset && wdt_download_reset)) else $error("two responses");
endmodule : wdl_top_props
bind wdl_top wdl_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_wdl_top_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .wdt_sys_reset,
  .wdt_download_reset, .wdt_irq);
`default_nettype wire

// ===== verification/wdl_top_tb.sv
`include "wdl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module wdl_top_tb;
  localparam int unsigned TICK = 64;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        por_n = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0000;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [15:0] s_axi_araddr = 16'h0000;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, wdt_sys_reset, wdt_download_reset, wdt_irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, last_resp;
  logic [31:0] s_axi_rdata;
  int          n_fail = 0;
  int          checks_done = 0;
  int          n_irq, n_rst, n_dl;

  wdl_top #(.TICK_CYCLES(TICK)) u_wdl_top (
    .aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wdt_sys_reset, .wdt_download_reset, .wdt_irq);

  always #2 aclk = ~aclk;

  // Pulse counters; a pin reset starts them again from zero.
  always @(posedge aclk) begin
    if (!aresetn) begin
      n_irq <= 0;
      n_rst <= 0;
      n_dl <= 0;
    end else begin
      if (wdt_irq === 1'b1) n_irq <= n_irq + 1;
      if (wdt_sys_reset === 1'b1) n_rst <= n_rst + 1;
      if (wdt_download_reset === 1'b1) n_dl <= n_dl + 1;
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rst(input logic por);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_n <= !por;
    repeat (8) @(posedge aclk);
    por_n <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready === 1'b1) begin
        aw_p = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        w_p = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
  endtask : rc

  // Arms the control write guard, then writes the control register.
  task automatic uw(input logic [31:0] d);
    wr(16'h0000, 32'h0000_0001);
    wr(16'h0000, d);
  endtask : uw

  task automatic t_regs();
    rst(1'b1);
    rc(16'h0000, 32'h0000_0072);
    rc(16'hFFE8, 32'h0000_00FF);
    rc(16'h000C, 32'h0000_0000);
    rc(16'h0010, 32'h0000_0000);
    chk({30'h0, last_resp}, {30'h0, `WDL_RESP_SLVERR});
    wr(16'h0002, 32'h0000_0001);
    chk({30'h0, last_resp}, {30'h0, `WDL_RESP_SLVERR});
    $display("test regs done");
  endtask : t_regs

  task automatic t_guard();
    wr(16'h0000, 32'h0000_000A);
    rc(16'h0000, 32'h0000_0072);
    uw(32'h0000_005A);
    rc(16'h0000, 32'h0000_005A);
    wr(16'h0000, 32'h0000_0001);
    rc(16'h000C, 32'h0000_0000);
    wr(16'h0000, 32'h0000_0032);
    rc(16'h0000, 32'h0000_005A);
    $display("test guard done");
  endtask : t_guard

  task automatic t_irq();
    rst(1'b0);
    uw(32'h0000_000A);
    repeat (3 * TICK + 10) @(posedge aclk);
    chk(n_irq, 3);
    chk(n_rst, 0);
    rc(16'h0000, 32'h0000_000E);
    uw(32'h0000_000A);
    rc(16'h0000, 32'h0000_000A);
    $display("test irq done");
  endtask : t_irq

  task automatic t_rst();
    rst(1'b0);
    repeat (4) begin
      uw(32'h0000_0002);
      repeat (TICK / 2) @(posedge aclk);
    end
    chk(n_rst, 0);
    repeat (TICK) @(posedge aclk);
    chk(n_rst, 1);
    rc(16'h0000, 32'h0000_0076);
    rst(1'b0);
    rc(16'h0000, 32'h0000_0072);
    $display("test reset done");
  endtask : t_rst

  task automatic t_codes();
    rst(1'b0);
    for (int c = 0; c < 16; c++) begin
      if (c == 8 || c == 9) continue;
      uw({24'h00_0000, c[3:0], 4'h2});
      rc(16'h0000, {24'h00_0000, (c < 8) ? c[3:0] : 4'h7, 4'h2});
    end
    uw(32'h0000_0082);
    repeat (4) @(posedge aclk);
    chk(n_rst, 1);
    uw(32'h0000_0092);
    repeat (4) @(posedge aclk);
    chk(n_dl, 1);
    $display("test codes done");
  endtask : t_codes

  task automatic t_lock();
    wr(16'hFFE8, 32'h0000_007F);
    rc(16'hFFE8, 32'h0000_007F);
    rst(1'b0);
    rc(16'h000C, 32'h0000_0001);
    uw(32'h0000_001C);
    rc(16'h0000, 32'h0000_0012);
    wr(16'h0008, 32'h0000_0012);
    wr(16'h0004, 32'h0000_00FF);
    rc(16'h000C, 32'h0000_0001);
    rc(16'hFFEC, 32'h0000_00FF);
    wr(16'h0004, 32'h0000_007F);
    rc(16'h000C, 32'h0000_0003);
    rc(16'hFFEC, 32'h0000_0012);
    $display("test lock done");
  endtask : t_lock

  initial begin
    t_regs();
    t_guard();
    t_irq();
    t_rst();
    t_codes();
    t_lock();
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_sim();
  end
endmodule : wdl_top_tb
`default_nettype wire
